//--- logic/three_phase_pwm_timing_unit.sv
// What this block does
// R1: dead time is twice count clocks
// R2: dead-time count 10 bits, max 0x3FF
// R3: zero count removes dead time
// R4: mode bit 6 selects update mode
// R5: single mode: one sync latches settings
// R6: sync edge also latches output steering
// R7: double mode: midpoint sync latches again
// R8: status bit 3 shows second half
// R9: sync pulse lasts width plus one
// R10: sync width resets to 0x27
// R11: duty counts give high on-time per half
// R12: waveforms centred in the period
// R13: edges shifted by dead time, symmetric
// R14: single mode on-times twice per half
// R15: on-times clamp between zero and period
// R16: double mode on-times sum both halves
// R17: double mode period sums both halves
// R18: outputs idle until four registers written
// R19: first sync 1.5 or 1 half-period
// R20: resolution two clocks single, one double
// R21: sync pulse goes to converter system
// R22: half-period counts clocks per half
// R23: interrupt pulse on every sync
// R24: three complementary active-high output pairs
// R25: up/down counter compared against latched counts
`timescale 1ns/1ps
`include "pwm_map.svh"
module three_phase_pwm_timing_unit import pwm_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic phase_a_high_out,
  output logic phase_a_low_out,
  output logic phase_b_high_out,
  output logic phase_b_low_out,
  output logic phase_c_high_out,
  output logic phase_c_low_out,
  output logic period_sync_pulse,
  output logic sync_interrupt
);
  unit_state_t state_reg;
  unit_state_t state_next;
  logic [2:0] hi;
  logic [2:0] lo;
  logic [2:0] xover;
  logic [2:0] dis_hi;
  logic [2:0] dis_lo;
  logic latch;
  logic last;
  logic [31:0] wv;

  // ==========================================
  // register helpers
  function automatic logic [31:0] reg_value(input unit_state_t s,
                                            input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `OFS_HALF_PERIOD: v[`TM_W-1:0] = s.tm;
      `OFS_DEAD_TIME: v[`DT_W-1:0] = s.dt; // [R2]
      `OFS_MIN_PULSE: v[`TM_W-1:0] = s.pd;
      `OFS_SYNC_WIDTH: v[`SW_W-1:0] = s.sw;
      `OFS_STEERING: v[`SEG_W-1:0] = s.seg;
      `OFS_MODE: v[`MODE_DOUBLE_BIT] = s.dbl;
      `OFS_STATUS: begin
        v[`STAT_HALF_BIT] = s.half; // [R8]
        v[`STAT_RUN_BIT] = (s.st == ST_RUN);
      end
      default: ;
    endcase
    for (int i = 0; i < 3; i++) begin
      if (a == `OFS_DUTY_A + 8'(i) * `OFS_DUTY_STEP) begin
        v[`TM_W-1:0] = s.duty[i];
      end
    end
    return v;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic m;
    m = (a <= `OFS_STATUS);
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    state_next = state_reg;
    latch = 1'b0;
    last = 1'b0;
    wv = 32'h0000_0000;

    // write channel: address and data in either order
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    if (awvalid && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = {awaddr[7:2], 2'h0};
    end
    if (wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = wdata;
      state_next.wstrb = wstrb;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      wv = merge(reg_value(state_reg, state_reg.awaddr),
                 state_reg.wdata, state_reg.wstrb);
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = is_mapped(state_reg.awaddr) ?
        `RESP_OKAY : `RESP_SLVERR;
      case (state_reg.awaddr)
        `OFS_HALF_PERIOD: begin
          state_next.tm = wv[`TM_W-1:0]; // [R22]
          state_next.written[0] = 1'b1; // [R18]
        end
        `OFS_DEAD_TIME: state_next.dt = wv[`DT_W-1:0]; // [R2]
        `OFS_MIN_PULSE: state_next.pd = wv[`TM_W-1:0];
        `OFS_SYNC_WIDTH: state_next.sw = wv[`SW_W-1:0];
        `OFS_STEERING: state_next.seg = wv[`SEG_W-1:0];
        `OFS_MODE: state_next.dbl = wv[`MODE_DOUBLE_BIT]; // [R4]
        default: ;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (state_reg.awaddr == `OFS_DUTY_A + 8'(i) * `OFS_DUTY_STEP)
        begin
          state_next.duty[i] = wv[`TM_W-1:0]; // [R11]
          state_next.written[i+1] = 1'b1; // [R18]
        end
      end
    end
    state_next.awready = !state_next.aw_got && !state_next.bvalid;
    state_next.wready = !state_next.w_got && !state_next.bvalid;

    // read channel: one read at a time
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = reg_value(state_reg, {araddr[7:2], 2'h0});
      state_next.rresp = is_mapped({araddr[7:2], 2'h0}) ?
        `RESP_OKAY : `RESP_SLVERR;
    end
    state_next.arready = !state_next.rvalid;

    // ==========================================
    // main timer: up in first half, down in second
    state_next.sync_go = 1'b0;
    state_next.irq = state_reg.sync_go; // [R23]
    case (state_reg.st)
      ST_WAIT_INIT: begin
        if (&state_reg.written) begin // [R18]
          state_next.st = ST_RUN;
          latch = 1'b1;
          state_next.half = 1'b0;
          // start mid-half so single mode waits 1.5 half-periods
          state_next.cnt = state_reg.dbl ?
            {`TM_W{1'b0}} : (state_reg.tm >> 1); // [R19]
        end
      end
      ST_RUN: begin
        last = state_reg.half ?
          (state_reg.cnt == {`TM_W{1'b0}}) :
          (state_reg.cnt == state_reg.a_tm - 16'h0001);
        if (!last) begin
          state_next.cnt = state_reg.half ?
            state_reg.cnt - 16'h0001 : state_reg.cnt + 16'h0001;
        end else if (!state_reg.half) begin
          state_next.half = 1'b1; // [R8]
          if (state_reg.dbl) begin
            latch = 1'b1; // [R7] [R17] [R20]
            state_next.sync_go = 1'b1; // [R21]
            state_next.cnt = state_reg.tm - 16'h0001; // [R16]
          end else begin
            // single mode reuses the same counts: symmetric period
            state_next.cnt = state_reg.a_tm - 16'h0001; // [R12] [R14]
          end
        end else begin
          state_next.half = 1'b0;
          state_next.cnt = {`TM_W{1'b0}};
          latch = 1'b1; // [R5]
          state_next.sync_go = 1'b1; // [R21]
        end
      end
      default: state_next.st = ST_WAIT_INIT;
    endcase

    // ==========================================
    // shadow to active transfer at each sync edge
    // writes landing this same cycle wait for the next edge
    if (latch) begin
      state_next.a_tm = state_reg.tm; // [R5]
      state_next.a_dt = state_reg.dt;
      state_next.a_pd = state_reg.pd;
      state_next.a_sw = state_reg.sw;
      state_next.a_duty = state_reg.duty;
      state_next.a_seg = state_reg.seg; // [R6]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.sw <= `RST_SYNC_WIDTH; // [R10]
      state_reg.a_sw <= `RST_SYNC_WIDTH;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // output stage
  assign xover = {state_reg.a_seg[`SEG_XOVER_C],
                  state_reg.a_seg[`SEG_XOVER_B],
                  state_reg.a_seg[`SEG_XOVER_A]};
  assign dis_hi = {state_reg.a_seg[`SEG_DIS_CH],
                   state_reg.a_seg[`SEG_DIS_BH],
                   state_reg.a_seg[`SEG_DIS_AH]};
  assign dis_lo = {state_reg.a_seg[`SEG_DIS_CL],
                   state_reg.a_seg[`SEG_DIS_BL],
                   state_reg.a_seg[`SEG_DIS_AL]};

  for (genvar g = 0; g < 3; g++) begin : gen_leg
    phase_leg leg (
      .clock(clock),
      .resetn(resetn),
      .run(state_reg.st == ST_RUN),
      .cnt(state_reg.cnt),
      .tm(state_reg.a_tm),
      .duty(state_reg.a_duty[g]),
      .dt(state_reg.a_dt),
      .xover(xover[g]),
      .dis_hi(dis_hi[g]),
      .dis_lo(dis_lo[g]),
      .hi_out(hi[g]),
      .lo_out(lo[g])
    );
  end

  sync_pulse_timer sync_timer (
    .clock(clock),
    .resetn(resetn),
    .start(state_reg.sync_go),
    .width(state_reg.a_sw),
    .pulse(period_sync_pulse)
  );

  assign phase_a_high_out = hi[0];
  assign phase_a_low_out = lo[0];
  assign phase_b_high_out = hi[1];
  assign phase_b_low_out = lo[1];
  assign phase_c_high_out = hi[2];
  assign phase_c_low_out = lo[2];
  assign sync_interrupt = state_reg.irq;
  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;
endmodule // three_phase_pwm_timing_unit

//--- logic/pwm_map.svh
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH
// ==========================================
// register offsets (byte addresses)
`define OFS_HALF_PERIOD 8'h00
`define OFS_DEAD_TIME 8'h04
`define OFS_MIN_PULSE 8'h08
`define OFS_SYNC_WIDTH 8'h0C
`define OFS_DUTY_A 8'h10
`define OFS_DUTY_STEP 8'h04
`define OFS_STEERING 8'h1C
`define OFS_MODE 8'h20
`define OFS_STATUS 8'h24
// ==========================================
// field widths and positions
`define TM_W 16
`define DT_W 10
`define SW_W 8
`define SEG_W 9
`define MODE_DOUBLE_BIT 6
`define STAT_HALF_BIT 3
`define STAT_RUN_BIT 0
`define SEG_XOVER_A 8
`define SEG_XOVER_B 7
`define SEG_XOVER_C 6
`define SEG_DIS_AH 4
`define SEG_DIS_AL 5
`define SEG_DIS_BH 3
`define SEG_DIS_BL 2
`define SEG_DIS_CH 1
`define SEG_DIS_CL 0
// ==========================================
// reset values and bus answers
`define RST_SYNC_WIDTH 8'h27
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- logic/pwm_pkg.sv
`include "pwm_map.svh"
package pwm_pkg;
  typedef enum logic [0:0] {
    ST_WAIT_INIT = 1'b0,
    ST_RUN = 1'b1
  } timer_state_t;

  typedef struct packed {
    timer_state_t st;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`TM_W-1:0] tm;
    logic [`DT_W-1:0] dt;
    logic [`TM_W-1:0] pd;
    logic [`SW_W-1:0] sw;
    logic [2:0][`TM_W-1:0] duty;
    logic [`SEG_W-1:0] seg;
    logic dbl;
    logic [3:0] written;
    logic [`TM_W-1:0] a_tm;
    logic [`DT_W-1:0] a_dt;
    logic [`TM_W-1:0] a_pd;
    logic [`SW_W-1:0] a_sw;
    logic [2:0][`TM_W-1:0] a_duty;
    logic [`SEG_W-1:0] a_seg;
    logic [`TM_W-1:0] cnt;
    logic half;
    logic sync_go;
    logic irq;
  } unit_state_t;

  typedef struct packed {
    logic active;
    logic [`SW_W-1:0] cnt;
  } sync_state_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } leg_state_t;
endpackage

//--- logic/sync_pulse_timer.sv
`timescale 1ns/1ps
`include "pwm_map.svh"
module sync_pulse_timer import pwm_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  input wire logic [`SW_W-1:0] width,
  output logic pulse
);
  sync_state_t state_reg;
  sync_state_t state_next;

  // ==========================================
  // pulse of width+1 clocks
  always_comb begin
    state_next = state_reg;
    if (start) begin // [R9]
      state_next.active = 1'b1;
      state_next.cnt = width;
    end else if (state_reg.active) begin
      if (state_reg.cnt == {`SW_W{1'b0}}) begin
        state_next.active = 1'b0;
      end else begin
        state_next.cnt = state_reg.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pulse = state_reg.active;
endmodule // sync_pulse_timer

//--- logic/phase_leg.sv
`timescale 1ns/1ps
`include "pwm_map.svh"
module phase_leg import pwm_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic run,
  input wire logic [`TM_W-1:0] cnt,
  input wire logic [`TM_W-1:0] tm,
  input wire logic [`TM_W-1:0] duty,
  input wire logic [`DT_W-1:0] dt,
  input wire logic xover,
  input wire logic dis_hi,
  input wire logic dis_lo,
  output logic hi_out,
  output logic lo_out
);
  leg_state_t state_reg;
  leg_state_t state_next;
  logic signed [17:0] pos;
  logic signed [17:0] hi_th;
  logic signed [17:0] lo_th;
  logic high;
  logic low;

  // ==========================================
  // edge placement about the half boundary
  // same compare on up and down count keeps edges symmetric
  always_comb begin
    pos = $signed({2'h0, cnt});
    hi_th = $signed({2'h0, tm}) - $signed({2'h0, duty})
      + $signed({8'h00, dt}); // [R13] [R25]
    lo_th = $signed({2'h0, tm}) - $signed({2'h0, duty})
      - $signed({8'h00, dt}); // [R1] [R3]
    // thresholds outside 0..tm give 0% or 100% for free
    high = run && (pos >= hi_th); // [R15] [R18]
    low = run && (pos < lo_th); // [R15] [R18]
    high = high && !dis_hi;
    low = low && !dis_lo;
    state_next.hi = xover ? low : high; // [R24]
    state_next.lo = xover ? high : low;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hi_out = state_reg.hi;
  assign lo_out = state_reg.lo;
endmodule // phase_leg

//--- bench/pwm_monitor.sv
`timescale 1ns/1ps
`include "pwm_map.svh"
module pwm_monitor import pwm_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic phase_a_high_out,
  input wire logic phase_a_low_out,
  input wire logic phase_b_high_out,
  input wire logic phase_b_low_out,
  input wire logic phase_c_high_out,
  input wire logic phase_c_low_out,
  input wire logic period_sync_pulse,
  input wire logic sync_interrupt
);
  // ====================
  // settings seen on the bus
  logic [7:0] a_q;
  logic [31:0] d_q;
  logic [15:0] tm;
  logic [9:0] dt;
  logic [7:0] sw;
  logic dbl, prev, arm, rise, ok;
  logic [3:0] seen;
  logic [1:0] quiet;
  logic [16:0] gap, gapa;
  logic [8:0] len;
  assign rise = period_sync_pulse && !prev;
  // checks wait three syncs after a write, new values latch late
  assign ok = quiet == 2'd3;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {a_q, d_q, tm, dt, dbl, prev, arm, seen, quiet, gap, gapa, len} <= 0;
      sw <= `RST_SYNC_WIDTH;
    end else begin
      if (awvalid && awready) a_q <= awaddr;
      if (wvalid && wready) d_q <= wdata;
      prev <= period_sync_pulse;
      len <= period_sync_pulse ? len + 9'd1 : 9'd0;
      gap <= rise ? 17'd1 : gap + 17'd1;
      arm <= phase_a_high_out ? 1'b1 : (phase_a_low_out ? 1'b0 : arm);
      gapa <= phase_a_high_out ? 17'd0 : gapa + 17'd1;
      if (rise && !ok) quiet <= quiet + 2'd1;
      if (bvalid && bready) begin
        quiet <= 2'd0;
        case (a_q)
          `OFS_HALF_PERIOD: begin
            tm <= d_q[15:0];
            seen[0] <= 1'b1;
          end
          `OFS_DEAD_TIME: dt <= d_q[9:0];
          `OFS_SYNC_WIDTH: sw <= d_q[7:0];
          `OFS_MODE: dbl <= d_q[`MODE_DOUBLE_BIT];
          `OFS_DUTY_A, `OFS_DUTY_A + `OFS_DUTY_STEP,
          `OFS_DUTY_A + 8'h08: seen[2'(a_q[3:2] + 2'd1)] <= 1'b1;
          default: ;
        endcase
      end
    end
  end
  // ====================
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_pair_exclusive: assert property (
    !(phase_a_high_out && phase_a_low_out) &&
    !(phase_b_high_out && phase_b_low_out) &&
    !(phase_c_high_out && phase_c_low_out)) else $error("pair both on");
  a_irq_on_rise: assert property (
    sync_interrupt == $rose(period_sync_pulse)) else $error("irq off sync");
  a_idle_before_init: assert property (seen != 4'hF |->
    !(phase_a_high_out || phase_a_low_out || phase_b_high_out ||
    phase_b_low_out || phase_c_high_out || phase_c_low_out))
    else $error("output before init");
  a_sync_width_len: assert property ($fell(period_sync_pulse) && ok |->
    len == {1'b0, sw} + 9'd1) else $error("sync width wrong");
  a_sync_period: assert property (rise && ok |->
    gap == (dbl ? {1'b0, tm} : {tm, 1'b0})) else $error("sync period");
  a_dead_gap_a: assert property ($rose(phase_a_low_out) && arm && ok |->
    gapa == {6'd0, dt, 1'b0}) else $error("dead gap wrong");
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("late write answer");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("late read answer");
  a_ready_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("ready during answer");
endmodule // pwm_monitor

bind three_phase_pwm_timing_unit pwm_monitor mon (.clock, .resetn,
  .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .phase_a_high_out, .phase_a_low_out,
  .phase_b_high_out, .phase_b_low_out, .phase_c_high_out,
  .phase_c_low_out, .period_sync_pulse, .sync_interrupt);

//--- bench/gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model import pwm_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic mark,
  input wire logic two_marks,
  input wire logic [2:0] hi,
  input wire logic [2:0] lo,
  output logic done,
  output logic [5:0][15:0] tally
);
  // ====================
  // on-time per switching period
  logic [5:0][15:0] acc;
  logic [5:0] now;
  logic odd;
  assign now = {lo, hi};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {acc, tally, done, odd} <= 0;
    end else begin
      done <= 1'b0;
      for (int i = 0; i < 6; i++) acc[i] <= acc[i] + 16'(now[i]);
      if (mark) begin
        odd <= !odd;
        if (!two_marks || odd) begin
          done <= 1'b1;
          tally <= acc;
          for (int i = 0; i < 6; i++) acc[i] <= 16'(now[i]);
        end
      end
    end
  end
endmodule // gate_driver_model

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "pwm_map.svh"
module testbench import pwm_pkg::*;;
  localparam int TM = 20;
  logic clock = 1'b0, resetn = 1'b0, dbl_w = 1'b0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, sync, irq, done;
  logic [1:0] bresp, rresp;
  logic [2:0] hi, lo;
  logic [5:0][15:0] tally, ep, last_e, es;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [5:0][15:0] pq[$];
  int bad_count = 0, compares = 0, cyc = 0, n, seed = 32'hB371;
  three_phase_pwm_timing_unit DUT (.clock, .resetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .phase_a_high_out(hi[0]), .phase_a_low_out(lo[0]),
    .phase_b_high_out(hi[1]), .phase_b_low_out(lo[1]),
    .phase_c_high_out(hi[2]), .phase_c_low_out(lo[2]),
    .period_sync_pulse(sync), .sync_interrupt(irq));
  gate_driver_model partner (.clock, .resetn, .mark(irq),
    .two_marks(dbl_w), .hi, .lo, .done, .tally);
  initial forever #2 clock = ~clock;
  // ====================
  // checking and ending
  task automatic chk(input logic [47:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test;
    end
  end
  always @(posedge clock) begin
    if (rvalid === 1'b1 && rready === 1'b1)
      chk({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1)
      chk(bresp, bq.pop_front());
    if (done === 1'b1 && pq.size() > 0) begin
      ep = pq.pop_front();
      for (int i = 0; i < 6; i++)
        chk(tally[i], ep[i]);
    end
  end
  // ====================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(a > `OFS_STATUS ? `RESP_SLVERR : `RESP_OKAY);
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // ====================
  // period windows
  function automatic logic [15:0] on(input int v);
    return 16'(2 * (v < 0 ? 0 : (v > TM ? TM : v)));
  endfunction
  task automatic expect_window(input logic [5:0][15:0] e);
    repeat (3) @(posedge clock iff done === 1'b1);
    pq.push_back(e);
    while (pq.size() != 0) @(posedge clock);
  endtask
  task automatic run_cfg(input logic m, input int dt, da, db, dc);
    int d[3];
    d = '{da, db, dc};
    wr(`OFS_DEAD_TIME, dt);
    wr(`OFS_MODE, {25'd0, m, 6'd0});
    dbl_w <= m;
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_DUTY_A + 8'(i) * `OFS_DUTY_STEP, d[i]);
      last_e[i] = on(d[i] - dt);
      last_e[i + 3] = on(TM - d[i] - dt);
    end
    expect_window(last_e);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(`OFS_SYNC_WIDTH, 34'h27);
    rd(`OFS_MODE, 34'h0);
    rd(8'h40, {`RESP_SLVERR, 32'h0});
    wr(8'h40, 32'h1);
    wr(`OFS_MIN_PULSE, 32'h1ABCD);
    rd(`OFS_MIN_PULSE, 34'hABCD);
    wr(`OFS_DEAD_TIME, 32'h7FF);
    rd(`OFS_DEAD_TIME, 34'h3FF);
    wr(`OFS_SYNC_WIDTH, 32'h3);
    for (int i = 0; i < 3; i++)
      wr(`OFS_DUTY_A + 8'(i) * `OFS_DUTY_STEP, 32'd12);
    wr(`OFS_HALF_PERIOD, TM);
    n = 0;
    while (sync !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    // edge of the start point is loosely defined, allow two clocks
    chk(48'(n * 2 >= 3 * TM - 4 && n * 2 <= 3 * TM + 4), 48'h1);
    run_cfg(1'b0, 2, 12, 1, 25);
    run_cfg(1'b0, 0, 12, 7, TM);
    // first half right after a sync, second half one half-period on
    @(posedge clock iff irq === 1'b1);
    rd(`OFS_STATUS, 34'h1);
    repeat (TM) @(posedge clock);
    rd(`OFS_STATUS, 34'h9);
    rd(`OFS_HALF_PERIOD, 34'(TM));
    run_cfg(1'b1, 3, 9, $unsigned($random(seed)) % TM, 14);
    wr(`OFS_STEERING, 32'h10F);
    es = '0;
    es[0] = last_e[3];
    es[3] = last_e[0];
    expect_window(es);
    wr(`OFS_STEERING, 32'h0);
    es = last_e;
    es[0] = 16'd19;
    es[3] = 16'd9;
    for (int k = 0; k < 10; k++) begin
      @(posedge clock iff irq === 1'b1);
      wr(`OFS_DUTY_A, k[0] ? 32'd12 : 32'd13);
      if (k == 5) pq.push_back(es);
    end
    while (pq.size() != 0) @(posedge clock);
    end_of_test;
  end
endmodule // testbench
